//--- rtl/uswc_suspend_ctrl.v
// How it works
// - PHY-on suspend keeps SuperSpeed PHY in U3 on own clock, others stopped.
// - PHY-off suspend disables PHY, suspends USB, stops clocks and PLLs.
// - All I/O pins hold level and configuration during either suspend.
// - PHY-off suspend keeps USB interface state unchanged.
// - Registers, buffer memory and RAM contents preserved in suspend.
// - Non-reset wake leaves the processor program counter unchanged.
// - Embedded firmware may request either suspend mode.
// - External processor may request suspend through mailbox write.
// - Wake on D+, D-, role-ID, SS resume, VBUS, CTS, control0, reset.
// - Wake by reset pin resets processor instead of resuming.
`include "uswc_defs.vh"

module uswc_suspend_ctrl #(
  parameter SETTLE = `USWC_PLL_SETTLE_CYC
) (
  input wire clk,
  input wire rst,
  input wire fwSuspendReq,
  input wire fwSuspendMode,
  input wire mboxSuspendReq,
  input wire mboxSuspendMode,
  input wire dPlus,
  input wire dMinus,
  input wire usbRoleIdPin,
  input wire superspeedReceiveResume,
  input wire vbusDetect,
  input wire uartCts,
  input wire ctsWakePolarity,
  input wire parallelPortControl0,
  input wire resetPin_n,
  input wire pllLocked,
  output reg suspendPhyOn,
  output reg suspendPhyOff,
  output reg phyEnable,
  output reg phyU3,
  output reg usbSuspend,
  output reg usbStateHold,
  output reg coreClockEnable,
  output reg pllEnable,
  output reg ioHold,
  output reg memRetain,
  output reg cpuHalt,
  output reg cpuPcReset,
  output wire wakeRequest,
  output reg [`USWC_WK_N-1:0] wakeCause
);
  reg [5:0] state;
  reg [5:0] next_state;
  reg mode;
  reg byReset;
  reg [15:0] settleCnt;
  wire arm;
  wire [`USWC_WK_N-1:0] pinLevel;
  wire [`USWC_WK_N-1:0] pinActive;
  wire [`USWC_WK_N-1:0] wakeSync;
  wire wakeRaw;
  wire reqAny;

  // State bit positions, one per one-hot state
  localparam B_RUN = `USWC_SB_RUN;
  localparam B_ENTER = `USWC_SB_ENTER;
  localparam B_ON = `USWC_SB_SUSP_ON;
  localparam B_OFF = `USWC_SB_SUSP_OFF;
  localparam B_WAKE = `USWC_SB_WAKE;
  localparam B_REL = `USWC_SB_RELEASE;

  assign reqAny = fwSuspendReq | mboxSuspendReq;
  assign arm = state[B_ON] | state[B_OFF];

  // Raw pins: the detector synchronises them itself
  assign pinLevel[`USWC_WK_DP] = dPlus;
  assign pinLevel[`USWC_WK_DM] = dMinus;
  assign pinLevel[`USWC_WK_ROLE] = usbRoleIdPin;
  assign pinLevel[`USWC_WK_SUPERSPEED_RECEIVE_PAIR] = superspeedReceiveResume;
  assign pinLevel[`USWC_WK_VBUS] = vbusDetect;
  assign pinLevel[`USWC_WK_CTS] = uartCts ~^ ctsWakePolarity;
  assign pinLevel[`USWC_WK_CTL0] = parallelPortControl0;
  assign pinLevel[`USWC_WK_RST] = ~resetPin_n;
  // Lines and role ID wake on any change; the rest on level
  assign pinActive = `USWC_WK_LEVEL_MASK;

  uswc_wake_detect #(
    .N(`USWC_WK_N)
  ) uDetect (
    .clk(clk),
    .rst(rst),
    .arm(arm),
    .pinLevel(pinLevel),
    .pinActive(pinActive),
    .wakeRaw(wakeRaw),
    .wakeSync(wakeSync)
  );

  // Raw request restarts the oscillator before any clock edge
  assign wakeRequest = wakeRaw;

  always @* begin
    next_state = state;
    case (state)
      `USWC_ST_RUN: begin
        // Transactions in flight are the requester's problem
        if (reqAny)
          next_state = `USWC_ST_ENTER;
      end
      `USWC_ST_ENTER: begin
        if (mode == `USWC_MODE_PHY_OFF)
          next_state = `USWC_ST_SUSP_OFF;
        else
          next_state = `USWC_ST_SUSP_ON;
      end
      `USWC_ST_SUSP_ON, `USWC_ST_SUSP_OFF: begin
        if (|wakeSync)
          next_state = `USWC_ST_WAKE;
      end
      `USWC_ST_WAKE: begin
        if (pllLocked && settleCnt == 16'h0000)
          next_state = `USWC_ST_RELEASE;
      end
      `USWC_ST_RELEASE: next_state = `USWC_ST_RUN;
      default: next_state = `USWC_ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state <= `USWC_ST_RUN;
      mode <= `USWC_MODE_PHY_ON;
      byReset <= 1'b0;
      settleCnt <= 16'h0000;
      wakeCause <= {`USWC_WK_N{1'b0}};
    end else begin
      state <= next_state;
      if (state[B_RUN] && reqAny)
        mode <= fwSuspendReq ? fwSuspendMode : mboxSuspendMode;
      if (arm && (|wakeSync)) begin
        wakeCause <= wakeSync;
        byReset <= wakeSync[`USWC_WK_RST];
        settleCnt <= SETTLE[15:0];
      end else if (state[B_WAKE] && pllLocked && settleCnt != 16'h0000)
        settleCnt <= settleCnt - 16'h0001;
      else if (state[B_WAKE] && !pllLocked)
        settleCnt <= SETTLE[15:0];
    end
  end

  // Registered control outputs
  always @(posedge clk) begin
    if (rst) begin
      suspendPhyOn <= 1'b0;
      suspendPhyOff <= 1'b0;
      phyEnable <= 1'b1;
      phyU3 <= 1'b0;
      usbSuspend <= 1'b0;
      usbStateHold <= 1'b0;
      coreClockEnable <= 1'b1;
      pllEnable <= 1'b1;
      ioHold <= 1'b0;
      memRetain <= 1'b0;
      cpuHalt <= 1'b0;
      cpuPcReset <= 1'b0;
    end else begin
      suspendPhyOn <= next_state[B_ON];
      suspendPhyOff <= next_state[B_OFF];
      phyEnable <= ~next_state[B_OFF];
      phyU3 <= next_state[B_ON];
      usbSuspend <= next_state[B_OFF];
      usbStateHold <= next_state[B_OFF];
      // Only the PHY's own clock survives PHY-on suspend
      coreClockEnable <= ~(next_state[B_ON] |
        next_state[B_OFF]);
      pllEnable <= ~next_state[B_OFF];
      ioHold <= next_state[B_ENTER] | next_state[B_ON] |
        next_state[B_OFF] | next_state[B_WAKE];
      // Retention held until clocks are back
      memRetain <= ~(next_state[B_RUN] | next_state[B_REL]);
      cpuHalt <= ~(next_state[B_RUN] | next_state[B_REL]);
      // Program counter untouched unless the reset pin woke us
      cpuPcReset <= next_state[B_REL] & byReset;
    end
  end
endmodule // uswc_suspend_ctrl

//--- rtl/uswc_defs.vh
`ifndef USWC_DEFS_VH
`define USWC_DEFS_VH

// Mode codes on the request ports
`define USWC_MODE_PHY_ON 1'b0
`define USWC_MODE_PHY_OFF 1'b1

// Sequencer state codes, one-hot
`define USWC_ST_RUN 6'h01
`define USWC_ST_ENTER 6'h02
`define USWC_ST_SUSP_ON 6'h04
`define USWC_ST_SUSP_OFF 6'h08
`define USWC_ST_WAKE 6'h10
`define USWC_ST_RELEASE 6'h20

// Bit position of each state in the one-hot code
`define USWC_SB_RUN 0
`define USWC_SB_ENTER 1
`define USWC_SB_SUSP_ON 2
`define USWC_SB_SUSP_OFF 3
`define USWC_SB_WAKE 4
`define USWC_SB_RELEASE 5

// PLL lock settle time in ns and its cycle count at 100 MHz
`define USWC_CLK_NS 10
`define USWC_PLL_SETTLE_NS 1000
`define USWC_PLL_SETTLE_CYC ((`USWC_PLL_SETTLE_NS + `USWC_CLK_NS - 1) / `USWC_CLK_NS)

// Wake source bit positions
`define USWC_WK_DP 0
`define USWC_WK_DM 1
`define USWC_WK_ROLE 2
`define USWC_WK_SUPERSPEED_RECEIVE_PAIR 3
`define USWC_WK_VBUS 4
`define USWC_WK_CTS 5
`define USWC_WK_CTL0 6
`define USWC_WK_RST 7
`define USWC_WK_N 8
// Sources that wake on a level; the rest wake on any change
`define USWC_WK_LEVEL_MASK 8'hf8

`endif

//--- rtl/uswc_wake_detect.v
`include "uswc_defs.vh"

// Wake sensing that needs no running clocks: pins pass a two-stage
// synchroniser only for the flag output, the wake level is raw so the
// analogue always-on domain can restart the oscillator.
module uswc_wake_detect #(
  parameter N = `USWC_WK_N
) (
  input wire clk,
  input wire rst,
  input wire arm,
  input wire [N-1:0] pinLevel,
  input wire [N-1:0] pinActive,
  output wire wakeRaw,
  output reg [N-1:0] wakeSync
);
  reg [N-1:0] stage1;
  reg [N-1:0] entryLevel;
  wire [N-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : gSrc
      // Edge sources compare with the level frozen at arm time
      assign hit[i] = pinActive[i] ? pinLevel[i] :
        (pinLevel[i] ^ entryLevel[i]);
    end
  endgenerate

  // Nothing but the second stage reads the first
  always @(posedge clk) begin
    if (rst) begin
      stage1 <= {N{1'b0}};
      wakeSync <= {N{1'b0}};
    end else begin
      stage1 <= {N{arm}} & hit;
      wakeSync <= stage1;
    end
  end

  // Reference captured while clocks still run, before suspend
  always @(posedge clk) begin
    if (rst)
      entryLevel <= {N{1'b0}};
    else if (!arm)
      entryLevel <= pinLevel;
  end

  assign wakeRaw = arm & (|hit);
endmodule // uswc_wake_detect

//--- tb/uswc_ctrl_props.sv
module uswc_ctrl_props (
  input wire clk,
  input wire rst,
  input wire fwSuspendReq,
  input wire fwSuspendMode,
  input wire mboxSuspendReq,
  input wire vbusDetect,
  input wire pllLocked,
  input wire suspendPhyOn,
  input wire suspendPhyOff,
  input wire phyEnable,
  input wire phyU3,
  input wire usbSuspend,
  input wire usbStateHold,
  input wire coreClockEnable,
  input wire pllEnable,
  input wire ioHold,
  input wire memRetain,
  input wire cpuHalt,
  input wire cpuPcReset,
  input wire [7:0] wakeCause
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_req_enter: assert property (
    !cpuHalt && !$past(cpuHalt) && (fwSuspendReq || mboxSuspendReq)
    |=> ioHold && cpuHalt && memRetain) else $error("no entry");
  chk_enter_mode: assert property (
    !cpuHalt && !$past(cpuHalt) && fwSuspendReq
    |-> ##2 (suspendPhyOff == fwSuspendMode)) else $error("bad mode");
  chk_phy_on: assert property (
    suspendPhyOn |-> phyEnable && phyU3 && !coreClockEnable)
    else $error("phy on state");
  chk_phy_off: assert property (
    suspendPhyOff |-> !phyEnable && usbSuspend && usbStateHold
    && !pllEnable && !coreClockEnable) else $error("phy off state");
  chk_io_hold: assert property (
    suspendPhyOn || suspendPhyOff |-> ioHold && memRetain)
    else $error("no hold");
  chk_wake_vbus: assert property (
    (suspendPhyOn || suspendPhyOff) && vbusDetect
    |-> ##[1:4] coreClockEnable) else $error("no wake");
  // Reset also drops the halt, so the reset edge is kept out
  chk_release_lock: assert property (
    $fell(cpuHalt) && !$past(rst) |-> $past(pllLocked)
    && $past(pllLocked, 2)) else $error("early release");
  chk_pc_cause: assert property (
    $fell(cpuHalt) && !$past(rst) |-> cpuPcReset == wakeCause[7])
    else $error("pc reset");
  cover property (suspendPhyOn);
  cover property (suspendPhyOff);
  cover property (cpuPcReset);
endmodule // uswc_ctrl_props
bind uswc_suspend_ctrl uswc_ctrl_props props (.clk(clk), .rst(rst),
  .fwSuspendReq(fwSuspendReq), .fwSuspendMode(fwSuspendMode),
  .mboxSuspendReq(mboxSuspendReq), .vbusDetect(vbusDetect),
  .pllLocked(pllLocked), .suspendPhyOn(suspendPhyOn),
  .suspendPhyOff(suspendPhyOff), .phyEnable(phyEnable), .phyU3(phyU3),
  .usbSuspend(usbSuspend), .usbStateHold(usbStateHold),
  .coreClockEnable(coreClockEnable), .pllEnable(pllEnable),
  .ioHold(ioHold), .memRetain(memRetain), .cpuHalt(cpuHalt),
  .cpuPcReset(cpuPcReset), .wakeCause(wakeCause));

//--- tb/uswc_host_model.sv
module uswc_host_model (
  input wire logic clk,
  output logic mboxSuspendReq,
  output logic mboxSuspendMode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mboxSuspendReq = 1'b0;
    mboxSuspendMode = 1'b0;
  end
  // Host drains its own traffic first; nothing is in flight
  task automatic request(input logic mode);
    @(negedge clk);
    mboxSuspendReq = 1'b1;
    mboxSuspendMode = mode;
    @(negedge clk);
    mboxSuspendReq = 1'b0;
  endtask
endmodule // uswc_host_model

//--- tb/test_usb_suspend_wake_control.sv
module test_usb_suspend_wake_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fwSuspendReq = 1'b0;
  logic fwSuspendMode = 1'b0;
  logic pllLocked = 1'b1;
  logic ctsPol = 1'b0;
  logic [7:0] pins = 8'ha0;
  wire mboxSuspendReq, mboxSuspendMode, suspendPhyOn, suspendPhyOff;
  wire phyEnable, phyU3, usbSuspend, usbStateHold, coreClockEnable;
  wire pllEnable, ioHold, memRetain, cpuHalt, cpuPcReset, wakeRequest;
  wire [7:0] wakeCause;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  uswc_host_model host (.*);
  uswc_suspend_ctrl #(.SETTLE(4)) dut (.*, .dPlus(pins[0]),
    .dMinus(pins[1]), .usbRoleIdPin(pins[2]),
    .superspeedReceiveResume(pins[3]), .vbusDetect(pins[4]),
    .uartCts(pins[5]), .ctsWakePolarity(ctsPol),
    .parallelPortControl0(pins[6]), .resetPin_n(pins[7]));
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic enter(input logic byMbox, input logic m);
    if (byMbox) begin
      host.request(m);
    end else begin
      @(negedge clk);
      fwSuspendReq = 1'b1;
      fwSuspendMode = m;
      @(negedge clk);
      fwSuspendReq = 1'b0;
    end
    repeat (2) @(negedge clk);
    check("mode", {suspendPhyOn, suspendPhyOff, phyU3, phyEnable,
      pllEnable, coreClockEnable, ioHold},
      {1'b0, ~m, m, ~m, ~m, ~m, 2'b01});
    check("hold", {usbSuspend, usbStateHold, memRetain, cpuHalt},
      {4'h0, m, m, 2'b11});
  endtask
  // Lock is withheld first so an early release would show
  task automatic wake(input int i);
    logic pc;
    pc = 1'b0;
    check("wakereq", {7'h00, wakeRequest}, 8'h00);
    pllLocked = 1'b0;
    pins[i] = ~pins[i];
    @(negedge clk);
    check("wakereq", {7'h00, wakeRequest}, 8'h01);
    repeat (9) @(negedge clk);
    check("halt", {7'h00, cpuHalt}, 8'h01);
    pllLocked = 1'b1;
    for (int k = 0; k < 20 && cpuHalt !== 1'b0; k++) begin
      @(negedge clk);
      pc = pc | cpuPcReset;
    end
    check("cause", wakeCause, 8'h01 << i);
    check("pcreset", {7'h00, pc}, {7'h00, i == 7});
    check("run", {cpuHalt, coreClockEnable, pllEnable, wakeRequest},
      8'h06);
    pins[i] = ~pins[i];
    @(negedge clk);
  endtask
  task automatic t_reset_state;
    check("reset", {phyEnable, coreClockEnable, pllEnable, cpuHalt,
      ioHold, suspendPhyOn, suspendPhyOff}, 8'h70);
    $display("reset state done");
  endtask
  task automatic t_all_sources;
    for (int i = 0; i < 8; i++) begin
      enter(i[0], i[1]);
      wake(i);
    end
    $display("wake sources done");
  endtask
  // Opposite polarity: clear-to-send idles low and wakes when high
  task automatic t_cts_polarity;
    pins[5] = 1'b0;
    ctsPol = 1'b1;
    enter(1'b1, 1'b0);
    wake(5);
    pins[5] = 1'b1;
    ctsPol = 1'b0;
    $display("cts polarity done");
  endtask
  // Reset while suspended must drop the I/O hold and halt and restore the enables
  task automatic t_mid_reset;
    enter(1'b0, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset_state();
    $display("mid-run reset done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset_state();
    t_all_sources();
    t_cts_polarity();
    t_mid_reset();
    end_sim();
  end
endmodule // test_usb_suspend_wake_control
